/* File: sks_apb_port.sv */
`timescale 1ns/10ps
module sks_apb_port
  import sks_pkg::*;
(
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  input  wire logic [7:0] paddr_i,
  output logic            pready_o,
  output logic            pslverr_o,
  output logic            wr_o,
  output logic            mapped_o
);

  // ----------------------------------------------------------------
  // Zero-wait decode
  // ----------------------------------------------------------------
  logic acc;

  always_comb
  begin
    acc       = psel_i && penable_i;
    mapped_o  = (paddr_i[1:0] == 2'h0) && (paddr_i <= SKS_OFF_AUTHCFG);
    pready_o  = 1'b1;
    pslverr_o = acc && !mapped_o;
    wr_o      = acc && pwrite_i && mapped_o;
  end

endmodule : sks_apb_port

/* File: sks_ft_model.sv */
`timescale 1ns/10ps
module sks_ft_model
  import sks_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       slow_i,
  input  wire logic       req_valid_i,
  input  wire logic [7:0] req_auth_alg_i,
  input  wire logic [7:0] req_cipher_alg_i,
  output logic            req_ready_o,
  output logic            rsp_valid_o,
  output logic            rsp_accept_o,
  output logic [7:0]      rsp_cause_o,
  output logic [7:0]      rsp_auth_alg_o,
  output logic [7:0]      rsp_cipher_alg_o,
  output logic            rsp_alt_auth_valid_o,
  output logic [7:0]      rsp_alt_auth_o,
  output logic            rsp_alt_cipher_valid_o,
  output logic [7:0]      rsp_alt_cipher_o
);
  // ----------------------------------------------------------------
  // Fixed side: supports auth 1..7 and cipher 1..3, offers 1 and 1
  // ----------------------------------------------------------------
  logic       pend;
  logic [3:0] cnt;
  logic [7:0] a;
  logic [7:0] c;
  logic       a_ok;
  logic       c_ok;
  assign a_ok = (a >= 8'h01) && (a <= 8'h07);
  assign c_ok = (c >= 8'h01) && (c <= 8'h03);
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {req_ready_o, rsp_valid_o, rsp_accept_o, pend, cnt, a, c} <= '0;
      {rsp_cause_o, rsp_auth_alg_o, rsp_cipher_alg_o} <= '0;
      {rsp_alt_auth_valid_o, rsp_alt_auth_o, rsp_alt_cipher_valid_o, rsp_alt_cipher_o} <= '0;
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      if (req_valid_i && req_ready_o)
      begin
        a           <= req_auth_alg_i;
        c           <= req_cipher_alg_i;
        pend        <= 1'b1;
        req_ready_o <= 1'b0;
        cnt         <= slow_i ? 4'h6 : 4'h0;
      end
      else if (pend && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (pend)
      begin
        pend                   <= 1'b0;
        rsp_valid_o            <= 1'b1;
        rsp_accept_o           <= a_ok && c_ok;
        rsp_auth_alg_o         <= a;
        rsp_cipher_alg_o       <= c;
        rsp_cause_o            <= (a == 8'h00) ? SKS_CAUSE_NO_AUTH :
                                  !a_ok ? SKS_CAUSE_AUTH_UNSUP :
                                  (c == 8'h00) ? SKS_CAUSE_NO_CIPHER :
                                  !c_ok ? SKS_CAUSE_CIPH_UNSUP : SKS_CAUSE_NONE;
        rsp_alt_auth_valid_o   <= 1'b1;
        rsp_alt_auth_o         <= 8'h01;
        rsp_alt_cipher_valid_o <= 1'b1;
        rsp_alt_cipher_o       <= 8'h01;
      end
      else
      begin
        req_ready_o <= 1'b1;
        if (rsp_valid_o)
        begin
          {rsp_cause_o, rsp_auth_alg_o, rsp_cipher_alg_o} <=
            ~{rsp_cause_o, rsp_auth_alg_o, rsp_cipher_alg_o};
          {rsp_alt_auth_o, rsp_alt_cipher_o} <= ~{rsp_alt_auth_o, rsp_alt_cipher_o};
        end
      end
    end
  end
endmodule : sks_ft_model

/* File: sks_key_store.sv */
`timescale 1ns/10ps
module sks_key_store
  import sks_pkg::*;
#(
  parameter int KEY_W   = 32,
  parameter int ENTRIES = 8
)(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             sel_cipher_i,
  input  wire logic [3:0]       sel_kind_i,
  input  wire logic [3:0]       sel_index_i,
  input  wire logic             wr_i,
  input  wire logic             clr_i,
  input  wire logic [KEY_W-1:0] wdata_i,
  input  wire logic             dck_wr_i,
  input  wire logic             dck_store_i,
  input  wire logic [3:0]       dck_index_i,
  input  wire logic [KEY_W-1:0] dck_i,
  output logic                  avail_o,
  output logic [KEY_W-1:0]      rdata_o
);

  if (ENTRIES < 1 || ENTRIES > SKS_MAX_ENTRIES) begin : g_chk
    $error("ENTRIES must lie in 1..8");
  end

  localparam logic [3:0] ENT4 = 4'(ENTRIES);

  typedef struct packed {
    logic [SKS_SLOTS-1:0][KEY_W-1:0] key;
    logic [SKS_SLOTS-1:0]            vld;
    logic                            avail;
    logic [KEY_W-1:0]                rdata;
  } sks_ks_s;

  sks_ks_s q, d;
  logic       sel_ok;
  logic [1:0] sel_rng;
  logic [5:0] sel_slot;
  logic [5:0] dck_slot;
  logic       dck_ok;

  // ----------------------------------------------------------------
  // Range decode and slot update
  // ----------------------------------------------------------------
  always_comb
  begin
    d       = q;
    sel_rng = SKS_RNG_USER_KEY;
    sel_ok  = 1'b1;
    if (!sel_cipher_i)
    begin
      case (sel_kind_i)
        SKS_AKIND_USER_KEY: sel_rng = SKS_RNG_USER_KEY;
        SKS_AKIND_CODE:     sel_rng = SKS_RNG_CODE;
        SKS_AKIND_KEY_PIN:  sel_rng = SKS_RNG_USER_KEY;
        default:            sel_ok  = 1'b0;
      endcase
    end
    else
    begin
      case (sel_kind_i)
        SKS_CKIND_STATIC:   sel_rng = SKS_RNG_STATIC;
        SKS_CKIND_DERIVED:  sel_rng = SKS_RNG_DERIVED;
        default:            sel_ok  = 1'b0;
      endcase
    end
    sel_ok   = sel_ok && ({1'b0, sel_index_i[2:0]} < ENT4);
    sel_slot = {sel_rng, sel_index_i};
    dck_slot = {SKS_RNG_DERIVED, dck_index_i};
    dck_ok   = {1'b0, dck_index_i[2:0]} < ENT4;
    if (clr_i && sel_ok)
    begin
      d.vld[sel_slot] = 1'b0;
    end
    if (wr_i && sel_ok)
    begin
      d.key[sel_slot] = wdata_i;
      d.vld[sel_slot] = 1'b1;
    end
    if (dck_wr_i && dck_store_i && dck_ok)
    begin
      d.key[dck_slot] = dck_i;
      d.vld[dck_slot] = 1'b1;
    end
    d.avail = sel_ok && q.vld[sel_slot];
    d.rdata = d.avail ? q.key[sel_slot] : '0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign avail_o = q.avail;
  assign rdata_o = q.rdata;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_dck_overwrite: assert property (
    dck_wr_i && dck_store_i && dck_ok
    |=> q.key[$past(dck_slot)] == $past(dck_i) && q.vld[$past(dck_slot)])
    else $error("derived key not overwritten");

  a_dck_discard: assert property (
    dck_wr_i && !dck_store_i && !wr_i && !clr_i
    |=> q.key[$past(dck_slot)] == $past(q.key[dck_slot]))
    else $error("derived key stored without flag");

  a_empty_unavail: assert property (
    !sel_ok |=> !avail_o && rdata_o == '0)
    else $error("bad slot reported available");

  a_pin_uses_key: assert property (
    !sel_cipher_i && sel_kind_i == SKS_AKIND_KEY_PIN && sel_ok
    |=> avail_o == $past(q.vld[{SKS_RNG_USER_KEY, sel_index_i}]))
    else $error("pin kind not mapped to user key");

endmodule : sks_key_store

/* File: sks_negotiator.sv */
`timescale 1ns/10ps
// Operation
// - Every rights request carries wished auth type and element_a elements.
// - Causes 11 and 17 leave only abort of the access attempt.
// - Cause 12 aborts or resends with a new auth type element.
// - Cause 18 aborts or resends with a new element_a element.
// - Accepted algorithms are recorded in the subscription details.
// - Store knows three auth key kinds and two cipher key kinds.
// - Per identity and per pair, user key and code ranges of eight.
// - Auth key kind and index are separate four-bit fields.
// - Index top bit: 0 identity alone, 1 identity plus rights key pair.
// - Combined key-and-pin kind addresses the stored user key part.
// - Allocation carries code index and target index for the new key.
// - Static and derived cipher key ranges of at most eight each.
// - Cipher key kind and index are four-bit; top bit selects association.
// - Storing a derived key overwrites the key held at that index.
// - Customary flow stores the derived key at index one, then ciphers.
module sks_negotiator
  import sks_pkg::*;
#(
  parameter int KEY_W   = 32,
  parameter int ENTRIES = 8
)(
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [7:0]       paddr_i,
  input  wire logic [31:0]      pwdata_i,
  output logic [31:0]           prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  output logic                  req_valid_o,
  input  wire logic             req_ready_i,
  output logic [7:0]            req_auth_alg_o,
  output logic [7:0]            req_cipher_alg_o,
  input  wire logic             rsp_valid_i,
  input  wire logic             rsp_accept_i,
  input  wire logic [7:0]       rsp_cause_i,
  input  wire logic [7:0]       rsp_auth_alg_i,
  input  wire logic [7:0]       rsp_cipher_alg_i,
  input  wire logic             rsp_alt_auth_valid_i,
  input  wire logic [7:0]       rsp_alt_auth_i,
  input  wire logic             rsp_alt_cipher_valid_i,
  input  wire logic [7:0]       rsp_alt_cipher_i,
  input  wire logic             dck_valid_i,
  input  wire logic [KEY_W-1:0] dck_i,
  output logic                  store_derived_key_flag_o,
  output logic [3:0]            cipher_key_index_field_o,
  output logic                  busy_o
);

  if (KEY_W < 1 || KEY_W > 32) begin : g_chk
    $error("KEY_W must lie in 1..32");
  end

  typedef struct packed {
    sks_state_e st;
    logic [7:0] auth_alg;
    logic [7:0] cipher_alg;
    logic [7:0] wish_auth;
    logic [7:0] wish_cipher;
    logic       retry_auth_en;
    logic       retry_cipher_en;
    logic [3:0] retry_max;
    logic [3:0] retry_cnt;
    logic       accepted;
    logic       aborted;
    logic [7:0] cause;
    logic       sub_valid;
    logic [7:0] sub_auth;
    logic [7:0] sub_cipher;
    logic       sel_cipher;
    logic [3:0] sel_kind;
    logic [3:0] sel_index;
    logic       store_flag;
    logic [3:0] dck_index;
  } sks_neg_s;

  sks_neg_s         q, d;
  logic             bus_wr;
  logic             bus_mapped;
  logic             key_wr;
  logic             key_clr;
  logic             key_avail;
  logic [KEY_W-1:0] key_rdata;
  logic             start_go;
  logic             rsp_take;
  logic             echo_ok;
  logic             can_retry;

  // ----------------------------------------------------------------
  // Bus front end and key store
  // ----------------------------------------------------------------
  sks_apb_port u_apb (
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .wr_o      (bus_wr),
    .mapped_o  (bus_mapped)
  );

  sks_key_store #(
    .KEY_W   (KEY_W),
    .ENTRIES (ENTRIES)
  ) u_store (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .sel_cipher_i (q.sel_cipher),
    .sel_kind_i   (q.sel_kind),
    .sel_index_i  (q.sel_index),
    .wr_i         (key_wr),
    .clr_i        (key_clr),
    .wdata_i      (pwdata_i[KEY_W-1:0]),
    .dck_wr_i     (dck_valid_i),
    .dck_store_i  (q.store_flag),
    .dck_index_i  (q.dck_index),
    .dck_i        (dck_i),
    .avail_o      (key_avail),
    .rdata_o      (key_rdata)
  );

  // ----------------------------------------------------------------
  // Register writes and exchange sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d         = q;
    key_wr    = bus_wr && (paddr_i == SKS_OFF_KEY_DATA);
    key_clr   = bus_wr && (paddr_i == SKS_OFF_KEY_CLR);
    start_go  = bus_wr && (paddr_i == SKS_OFF_CTRL) && pwdata_i[SKS_CTRL_START_BIT]
                && (q.st == SKS_IDLE);
    rsp_take  = (q.st == SKS_WAIT) && rsp_valid_i;
    echo_ok   = (rsp_auth_alg_i == q.auth_alg) && (rsp_cipher_alg_i == q.cipher_alg);
    can_retry = q.retry_cnt < q.retry_max;
    if (bus_wr)
    begin
      case (paddr_i)
        SKS_OFF_CTRL:
        begin
          d.retry_auth_en   = pwdata_i[SKS_CTRL_RAUTH_BIT];
          d.retry_cipher_en = pwdata_i[SKS_CTRL_RCIPH_BIT];
        end
        SKS_OFF_WISH:
        begin
          d.wish_auth   = pwdata_i[7:0];
          d.wish_cipher = pwdata_i[15:8];
        end
        SKS_OFF_KEY_SEL:
        begin
          d.sel_kind   = pwdata_i[3:0];
          d.sel_index  = pwdata_i[7:4];
          d.sel_cipher = pwdata_i[SKS_SEL_CIPHER_BIT];
        end
        SKS_OFF_RETRY:   d.retry_max = pwdata_i[3:0];
        SKS_OFF_AUTHCFG:
        begin
          d.store_flag = pwdata_i[SKS_AUTHCFG_STORE_BIT];
          d.dck_index  = pwdata_i[7:4];
        end
        default: ;
      endcase
    end
    case (q.st)
      SKS_IDLE:
      begin
        if (start_go)
        begin
          d.st         = SKS_SEND;
          d.auth_alg   = q.wish_auth;
          d.cipher_alg = q.wish_cipher;
          d.retry_cnt  = 4'h0;
          d.accepted   = 1'b0;
          d.aborted    = 1'b0;
          d.cause      = SKS_CAUSE_NONE;
        end
      end
      SKS_SEND:
      begin
        if (req_ready_i)
        begin
          d.st = SKS_WAIT;
        end
      end
      SKS_WAIT:
      begin
        if (rsp_take)
        begin
          d.st = SKS_IDLE;
          if (rsp_accept_i && echo_ok)
          begin
            d.accepted   = 1'b1;
            d.sub_valid  = 1'b1;
            d.sub_auth   = rsp_auth_alg_i;
            d.sub_cipher = rsp_cipher_alg_i;
          end
          else if (rsp_accept_i)
          begin
            d.aborted = 1'b1;
            d.cause   = SKS_CAUSE_ECHO_BAD;
          end
          else
          begin
            d.cause   = rsp_cause_i;
            d.aborted = 1'b1;
            case (rsp_cause_i)
              SKS_CAUSE_AUTH_UNSUP:
              begin
                if (q.retry_auth_en && rsp_alt_auth_valid_i && can_retry)
                begin
                  d.st        = SKS_SEND;
                  d.aborted   = 1'b0;
                  d.auth_alg  = rsp_alt_auth_i;
                  d.retry_cnt = q.retry_cnt + 4'h1;
                end
              end
              SKS_CAUSE_CIPH_UNSUP:
              begin
                if (q.retry_cipher_en && rsp_alt_cipher_valid_i && can_retry)
                begin
                  d.st         = SKS_SEND;
                  d.aborted    = 1'b0;
                  d.cipher_alg = rsp_alt_cipher_i;
                  d.retry_cnt  = q.retry_cnt + 4'h1;
                end
              end
              default: ;
            endcase
          end
        end
      end
      default: d.st = SKS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q             <= '0;
      q.st          <= SKS_IDLE;
      q.wish_auth   <= SKS_RST_WISH_AUTH;
      q.wish_cipher <= SKS_RST_WISH_CIPHER;
      q.retry_max   <= SKS_RST_RETRY_MAX;
      q.dck_index   <= SKS_RST_DCK_INDEX;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and read mux
  // ----------------------------------------------------------------
  assign req_valid_o              = (q.st == SKS_SEND);
  assign req_auth_alg_o           = q.auth_alg;
  assign req_cipher_alg_o         = q.cipher_alg;
  assign store_derived_key_flag_o = q.store_flag;
  assign cipher_key_index_field_o = q.dck_index;
  assign busy_o                   = (q.st != SKS_IDLE);

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (psel_i && bus_mapped && !pwrite_i)
    begin
      case (paddr_i)
        SKS_OFF_CTRL:     prdata_o = {29'h0, q.retry_cipher_en, q.retry_auth_en, 1'b0};
        SKS_OFF_WISH:     prdata_o = {16'h0, q.wish_cipher, q.wish_auth};
        SKS_OFF_STATUS:   prdata_o = {16'h0, q.cause, 1'b0, busy_o, q.aborted, q.accepted,
                                      2'h0, q.st};
        SKS_OFF_SUBSCR:   prdata_o = {15'h0, q.sub_valid, q.sub_cipher, q.sub_auth};
        SKS_OFF_KEY_SEL:  prdata_o = {23'h0, q.sel_cipher, q.sel_index, q.sel_kind};
        SKS_OFF_KEY_DATA: prdata_o = 32'(key_rdata);
        SKS_OFF_KEY_STAT: prdata_o = {31'h0, key_avail};
        SKS_OFF_RETRY:    prdata_o = {24'h0, q.retry_cnt, q.retry_max};
        SKS_OFF_AUTHCFG:  prdata_o = {24'h0, q.dck_index, 3'h0, q.store_flag};
        default:          prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    start_go;
  endsequence

  sequence s_reject(logic [7:0] c);
    rsp_take && !rsp_accept_i && rsp_cause_i == c;
  endsequence

  a_req_both_elems: assert property (
    s_start |=> req_valid_o && req_auth_alg_o == $past(q.wish_auth)
                && req_cipher_alg_o == $past(q.wish_cipher))
    else $error("request lacks wished elements");

  a_req_hold: assert property (
    req_valid_o && !req_ready_i
    |=> req_valid_o && $stable(req_auth_alg_o) && $stable(req_cipher_alg_o))
    else $error("request changed before taken");

  a_no_auth_abort: assert property (
    s_reject(SKS_CAUSE_NO_AUTH) or s_reject(SKS_CAUSE_NO_CIPHER)
    |=> q.aborted && !busy_o ##1 !req_valid_o)
    else $error("fatal cause did not abort");

  a_auth_retry: assert property (
    s_reject(SKS_CAUSE_AUTH_UNSUP) ##0 (q.retry_auth_en && rsp_alt_auth_valid_i && can_retry)
    |=> req_valid_o && req_auth_alg_o == $past(rsp_alt_auth_i)
        && req_cipher_alg_o == $past(q.cipher_alg))
    else $error("auth retry not resent");

  a_cipher_retry: assert property (
    s_reject(SKS_CAUSE_CIPH_UNSUP) ##0 (q.retry_cipher_en && rsp_alt_cipher_valid_i
                                       && can_retry)
    |=> req_valid_o && req_cipher_alg_o == $past(rsp_alt_cipher_i))
    else $error("cipher retry not resent");

  a_accept_record: assert property (
    rsp_take && rsp_accept_i && echo_ok
    |=> q.sub_valid && q.accepted && q.sub_auth == $past(rsp_auth_alg_i)
        && q.sub_cipher == $past(rsp_cipher_alg_i))
    else $error("accepted algorithms not recorded");

  a_echo_check: assert property (
    rsp_take && rsp_accept_i && !echo_ok
    |=> q.aborted && !q.accepted && q.cause == SKS_CAUSE_ECHO_BAD)
    else $error("bad echo accepted");

  a_retry_bound: assert property (
    busy_o |-> q.retry_cnt <= q.retry_max || q.retry_cnt == 4'h0)
    else $error("retry count past limit");

endmodule : sks_negotiator

/* File: sks_pkg.sv */
package sks_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SKS_OFF_CTRL     = 8'h00;
  localparam logic [7:0] SKS_OFF_WISH     = 8'h04;
  localparam logic [7:0] SKS_OFF_STATUS   = 8'h08;
  localparam logic [7:0] SKS_OFF_SUBSCR   = 8'h0C;
  localparam logic [7:0] SKS_OFF_KEY_SEL  = 8'h10;
  localparam logic [7:0] SKS_OFF_KEY_DATA = 8'h14;
  localparam logic [7:0] SKS_OFF_KEY_STAT = 8'h18;
  localparam logic [7:0] SKS_OFF_KEY_CLR  = 8'h1C;
  localparam logic [7:0] SKS_OFF_RETRY    = 8'h20;
  localparam logic [7:0] SKS_OFF_AUTHCFG  = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SKS_CTRL_START_BIT  = 0;
  localparam int SKS_CTRL_RAUTH_BIT  = 1;
  localparam int SKS_CTRL_RCIPH_BIT  = 2;
  localparam int SKS_SEL_CIPHER_BIT  = 8;
  localparam int SKS_STAT_ACC_BIT    = 4;
  localparam int SKS_STAT_ABT_BIT    = 5;
  localparam int SKS_STAT_BUSY_BIT   = 6;
  localparam int SKS_SUB_VALID_BIT   = 16;
  localparam int SKS_AUTHCFG_STORE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SKS_RST_WISH_AUTH   = 8'h01;
  localparam logic [7:0] SKS_RST_WISH_CIPHER = 8'h01;
  localparam logic [3:0] SKS_RST_RETRY_MAX   = 4'h3;
  localparam logic [3:0] SKS_RST_DCK_INDEX   = 4'h1;

  // ----------------------------------------------------------------
  // Reject causes
  // ----------------------------------------------------------------
  localparam logic [7:0] SKS_CAUSE_NONE       = 8'h00;
  localparam logic [7:0] SKS_CAUSE_NO_AUTH    = 8'h0B;
  localparam logic [7:0] SKS_CAUSE_AUTH_UNSUP = 8'h0C;
  localparam logic [7:0] SKS_CAUSE_NO_CIPHER  = 8'h11;
  localparam logic [7:0] SKS_CAUSE_CIPH_UNSUP = 8'h12;
  localparam logic [7:0] SKS_CAUSE_ECHO_BAD   = 8'hFF;

  // ----------------------------------------------------------------
  // Key kinds and store ranges
  // ----------------------------------------------------------------
  localparam logic [3:0] SKS_AKIND_USER_KEY = 4'h1;
  localparam logic [3:0] SKS_AKIND_CODE     = 4'h2;
  localparam logic [3:0] SKS_AKIND_KEY_PIN  = 4'h3;
  localparam logic [3:0] SKS_CKIND_STATIC   = 4'h1;
  localparam logic [3:0] SKS_CKIND_DERIVED  = 4'h2;
  localparam logic [1:0] SKS_RNG_USER_KEY   = 2'h0;
  localparam logic [1:0] SKS_RNG_CODE       = 2'h1;
  localparam logic [1:0] SKS_RNG_STATIC     = 2'h2;
  localparam logic [1:0] SKS_RNG_DERIVED    = 2'h3;
  localparam int         SKS_SLOTS          = 64;
  localparam int         SKS_MAX_ENTRIES    = 8;

  typedef enum logic [1:0] {SKS_IDLE, SKS_SEND, SKS_WAIT} sks_state_e;

endpackage : sks_pkg

/* File: tb_security_key_store_negotiation.sv */
`timescale 1ns/10ps
module tb_security_key_store_negotiation;
  import sks_pkg::*;
  logic        clk_sys_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, dck_v = 0, slow = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, derived_cipher_key = 0, prdata, r;
  logic [39:0] ca = 40'h00_0109_0907, cc = 40'h01_0001_0403;
  logic        pready, pslverr, req_v, req_r, rv, racc, aav, acv, sflag, busy;
  logic [7:0]  req_a, req_c, rcause, ra, rc, alt_a, alt_c, a, c;
  logic [3:0]  ck_idx;
  logic [24:0] ex;
  logic        e, ren_a, ren_c;
  int          err_total = 0, n_tests = 0, k;

  sks_negotiator i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .req_valid_o(req_v), .req_ready_i(req_r), .req_auth_alg_o(req_a),
    .req_cipher_alg_o(req_c), .rsp_valid_i(rv), .rsp_accept_i(racc), .rsp_cause_i(rcause),
    .rsp_auth_alg_i(ra), .rsp_cipher_alg_i(rc), .rsp_alt_auth_valid_i(aav),
    .rsp_alt_auth_i(alt_a), .rsp_alt_cipher_valid_i(acv), .rsp_alt_cipher_i(alt_c),
    .dck_valid_i(dck_v), .dck_i(derived_cipher_key), .store_derived_key_flag_o(sflag),
    .cipher_key_index_field_o(ck_idx), .busy_o(busy));
  sks_ft_model i_ft (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow), .req_valid_i(req_v),
    .req_auth_alg_i(req_a), .req_cipher_alg_i(req_c), .req_ready_o(req_r), .rsp_valid_o(rv),
    .rsp_accept_o(racc), .rsp_cause_o(rcause), .rsp_auth_alg_o(ra), .rsp_cipher_alg_o(rc),
    .rsp_alt_auth_valid_o(aav), .rsp_alt_auth_o(alt_a), .rsp_alt_cipher_valid_o(acv),
    .rsp_alt_cipher_o(alt_c));

  initial forever #5 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] ex_v, input logic [31:0] got);
    n_tests++;
    if (got !== ex_v)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, ex_v, got);
    end
  endtask : chk

  task automatic report_and_stop;
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  function automatic logic [24:0] expect_neg(input logic [7:0] a0, input logic [7:0] c0,
                                             input logic ea, input logic ec);
    logic [7:0] x;
    logic [7:0] y;
    x = a0;
    y = c0;
    if (x == 8'h00) return {1'b0, SKS_CAUSE_NO_AUTH, 16'h0000};
    if (x > 8'h07 && !ea) return {1'b0, SKS_CAUSE_AUTH_UNSUP, 16'h0000};
    if (x > 8'h07) x = 8'h01;
    if (y == 8'h00) return {1'b0, SKS_CAUSE_NO_CIPHER, 16'h0000};
    if (y > 8'h03 && !ec) return {1'b0, SKS_CAUSE_CIPH_UNSUP, 16'h0000};
    if (y > 8'h03) y = 8'h01;
    return {1'b1, 8'h00, y, x};
  endfunction : expect_neg

  task automatic key(input logic [8:0] sel, input logic [31:0] ex_d, input logic av);
    apb(1'b1, SKS_OFF_KEY_SEL, {23'h0, sel});
    apb(1'b0, SKS_OFF_KEY_STAT, 32'h0);
    chk("key_avail", {31'h0, av}, r);
    apb(1'b0, SKS_OFF_KEY_DATA, 32'h0);
    chk("key_data", ex_d, r);
  endtask : key

  task automatic dck_pulse(input logic [31:0] v);
    @(posedge clk_sys_i);
    dck_v <= 1'b1;
    derived_cipher_key   <= v;
    @(posedge clk_sys_i);
    dck_v <= 1'b0;
    derived_cipher_key   <= ~v;
  endtask : dck_pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(41));
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(1'b0, SKS_OFF_WISH, 32'h0);
    chk("wish_reset", 32'h0000_0101, r);
    apb(1'b0, SKS_OFF_RETRY, 32'h0);
    chk("retry_max", 32'h0000_0003, r & 32'h0000_000F);
    apb(1'b0, SKS_OFF_AUTHCFG, 32'h0);
    chk("authcfg_reset", 32'h0000_0010, r);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped_err", 32'h0000_0001, {31'h0, e});
    for (k = 0; k < 30; k++)
    begin
      a = (k < 5) ? ca[8*(4-k)+:8] : 8'($urandom_range(0, 9));
      c = (k < 5) ? cc[8*(4-k)+:8] : 8'($urandom_range(0, 4));
      ren_a = (k < 5) ? (k == 3) : 1'($urandom);
      ren_c = (k < 5) ? (k == 3) : 1'($urandom);
      slow <= 1'($urandom);
      ex = expect_neg(a, c, ren_a, ren_c);
      apb(1'b1, SKS_OFF_WISH, {16'h0, c, a});
      apb(1'b1, SKS_OFF_CTRL, {29'h0, ren_c, ren_a, 1'b1});
      @(posedge clk_sys_i);
      while (busy !== 1'b0) @(posedge clk_sys_i);
      apb(1'b0, SKS_OFF_STATUS, 32'h0);
      chk("accepted", {31'h0, ex[24]}, {31'h0, r[SKS_STAT_ACC_BIT]});
      chk("aborted", {31'h0, !ex[24]}, {31'h0, r[SKS_STAT_ABT_BIT]});
      if (!ex[24]) chk("cause", {24'h0, ex[23:16]}, {24'h0, r[15:8]});
      apb(1'b0, SKS_OFF_SUBSCR, 32'h0);
      if (ex[24]) chk("subscr", {15'h0, 1'b1, ex[15:0]}, r);
    end
    key(9'h021, 32'h0, 1'b0);
    apb(1'b1, SKS_OFF_KEY_DATA, 32'hA5A5_0001);
    apb(1'b1, SKS_OFF_KEY_SEL, 32'h0000_0022);
    apb(1'b1, SKS_OFF_KEY_DATA, 32'hB6B6_0002);
    apb(1'b1, SKS_OFF_KEY_SEL, 32'h0000_00A1);
    apb(1'b1, SKS_OFF_KEY_DATA, 32'hC7C7_0003);
    apb(1'b1, SKS_OFF_KEY_SEL, 32'h0000_0121);
    apb(1'b1, SKS_OFF_KEY_DATA, 32'hD8D8_0004);
    key(9'h021, 32'hA5A5_0001, 1'b1);
    key(9'h023, 32'hA5A5_0001, 1'b1);
    key(9'h022, 32'hB6B6_0002, 1'b1);
    key(9'h0A1, 32'hC7C7_0003, 1'b1);
    key(9'h121, 32'hD8D8_0004, 1'b1);
    key(9'h122, 32'h0, 1'b0);
    key(9'h024, 32'h0, 1'b0);
    key(9'h031, 32'h0, 1'b0);
    apb(1'b1, SKS_OFF_KEY_SEL, 32'h0000_0021);
    apb(1'b1, SKS_OFF_KEY_CLR, 32'h0);
    key(9'h021, 32'h0, 1'b0);
    apb(1'b1, SKS_OFF_AUTHCFG, 32'h0000_0011);
    dck_pulse(32'h1234_5678);
    key(9'h112, 32'h1234_5678, 1'b1);
    dck_pulse(32'h8765_4321);
    key(9'h112, 32'h8765_4321, 1'b1);
    apb(1'b1, SKS_OFF_AUTHCFG, 32'h0000_0050);
    @(posedge clk_sys_i);
    chk("cipher_idx", 32'h5, {28'h0, ck_idx});
    chk("store_flag", 32'h0, {31'h0, sflag});
    dck_pulse(32'h0F0F_0F0F);
    key(9'h152, 32'h0, 1'b0);
    report_and_stop();
  end

  initial
  begin
    #100_000;
    err_total++;
    report_and_stop();
  end
endmodule : tb_security_key_store_negotiation
